// ---- hw/lid_defines.svh ----
`ifndef LID_DEFINES_SVH
`define LID_DEFINES_SVH

// Clock period of the block clock, in ns
`define LID_CLK_NS        8
// Documented times in ns (oscillator at 180 kHz)
`define LID_RST_LOW_NS    1200000
`define LID_INIT_BUSY_NS  6000000
`define LID_CLEAR_NS      5420000
`define LID_EXEC_NS       83400
`define LID_BLINK_NS      480000000
// Least times round up, longest times round down
`define LID_CYC_UP(ns)    (((ns) + `LID_CLK_NS - 1) / `LID_CLK_NS)
`define LID_CYC_DN(ns)    ((ns) / `LID_CLK_NS)

// Memory map of the address pointer
`define LID_CHAR_TOP      7'h3f
`define LID_GLYPH_BASE    7'h40
`define LID_ICON_BASE     7'h60
`define LID_SPACE_CODE    8'h20
`define LID_ROW_LAST      4'hb

// Instruction code bit positions
`define LID_B_ADDR_SET    7
`define LID_B_CONTRAST    6
`define LID_B_FUNCTION    5
`define LID_B_SHIFT       4
`define LID_B_DISPLAY     3
`define LID_B_ENTRY       2
`define LID_B_HOME        1
`define LID_B_CLEAR       0

`endif

// ---- hw/lid_pkg.sv ----
package lid_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DECODE,
    ST_CLEAR,
    ST_WAIT
  } lid_state_t;

  // One transfer from the serial front end
  typedef struct packed {
    logic       register_select;
    logic       rw;
    logic [7:0] data;
  } lid_xfer_t;

  // Display mode bits handed to the panel drivers
  typedef struct packed {
    logic       display_visible;
    logic       cursor_visible;
    logic       cursor_blink;
    logic       blink_phase;
    logic [4:0] cursor_dots;
    logic [3:0] display_offset;
    logic       power_down;
    logic [3:0] contrast_level;
  } lid_disp_t;

  // Whole state of the decoder
  typedef struct packed {
    lid_state_t st;
    logic [31:0] cnt;
    logic [31:0] low_cnt;
    logic        pin_m;
    logic        pin_s;
    logic        pin_d;
    logic [7:0]  instruction_holding_register;
    logic [7:0]  data_holding_register;
    logic        hold_select;
    logic [6:0]  addr;
    logic        step_inc;
    logic        shift_en;
    lid_disp_t   disp;
    logic [31:0] blink_cnt;
    logic [6:0]  clr_addr;
    logic        mem_we;
    logic [6:0]  mem_addr;
    logic [7:0]  mem_data;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        busy;
  } lid_regs_t;

endpackage

// ---- hw/lid_ram.sv ----
`timescale 1ns/1ps
`default_nettype none

// Shared character, glyph and icon memory; scan read is registered
module lid_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          i_clk,
  // Write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  // Read port
  input  wire logic [AW-1:0] i_raddr,
  output var  logic [DW-1:0] o_rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // No reset on the array: icon contents survive reset by design
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule

`default_nettype wire

// ---- hw/lid_decoder.sv ----
// Notes on behaviour
// - Reset sequence runs only after the reset pin stayed low over 1.2 ms.
// - After reset pin rises, busy is reported for 6 ms.
// - Select low loads instruction holder, select high loads data holder.
// - Clear fills character memory with 20h, zeroes pointer, forces increment.
// - Clear keeps shift enable, icon memory and glyph memory.
// - Return home zeroes pointer and display shift, keeps memory, 83.4 us.
// - Entry mode latches step direction and display shift enable.
// - Step one adds one per access, step zero subtracts one.
// - Shift enabled writes to characters shift the display opposite the step.
// - No display shift on character reads or any glyph memory access.
// - Display control latches display, cursor and blink visibility.
// - Display off blanks panel but keeps character memory.
// - Visible cursor is five dots on the eighth line.
// - Blink has a 480 ms period; cursor and blink may combine.
// - Shift instruction: target and direction bits, RAM untouched, timing.
// - Function set bit 0: zero enters power-down, one cancels it.
// - Contrast set loads the low four bits into contrast level.
// - Address set loads seven bits into pointer, takes 83.4 us.
// - Key read returns scanned key data when key readout select is one.
// - Data write stores byte at pointer into memory, takes 83.4 us.
// - Execution times scale with the clock; figures assume 180 kHz.
// - Pointer map: rows at 00,10,20,30h, glyphs 40-5Fh, icons 60-7Fh.
// - Shift target zero moves cursor, one shifts display; direction one right.
// - Every data write steps the pointer by the latched direction.
`timescale 1ns/1ps
`default_nettype none
`include "lid_defines.svh"

module lid_decoder
  import lid_pkg::*;
#(
  parameter logic [31:0] RST_LOW_CYC  = `LID_CYC_UP(`LID_RST_LOW_NS),
  parameter logic [31:0] INIT_CYC     = `LID_CYC_UP(`LID_INIT_BUSY_NS),
  parameter logic [31:0] CLEAR_CYC    = `LID_CYC_UP(`LID_CLEAR_NS),
  parameter logic [31:0] EXEC_CYC     = `LID_CYC_UP(`LID_EXEC_NS),
  parameter logic [31:0] BLINK_HALF   = `LID_CYC_DN(`LID_BLINK_NS / 2)
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Reset pin, asynchronous, active low
  input  wire logic       i_reset_pin_n,
  // Transfers from the serial front end
  input  wire logic       i_xfer_valid,
  input  wire lid_xfer_t  i_xfer,
  // Key scan readout
  input  wire logic       i_key_readout_select,
  input  wire logic [7:0] i_key_data,
  // Panel scan access to the memory
  input  wire logic [6:0] i_scan_addr,
  output var  logic [7:0] o_scan_data,
  // Read answer and status
  output var  logic [7:0] o_read_data,
  output var  logic       o_read_valid,
  output var  logic       o_busy,
  output var  logic [6:0] o_ram_address_pointer,
  output var  logic       o_step_inc,
  output var  logic       o_shift_enable,
  // Display mode
  output var  lid_disp_t  o_disp
);

  lid_regs_t r;
  lid_regs_t n;

  // pointer steps by one, wrapping in 7 bits
  function automatic logic [6:0] lid_step(input logic [6:0] a,
                                          input logic inc);
    return inc ? 7'(a + 7'h01) : 7'(a - 7'h01);
  endfunction

  // Display offset counts left shifts, modulo one row of twelve
  function automatic logic [3:0] lid_shift(input logic [3:0] o,
                                           input logic left);
    logic [3:0] res;
    res = o;
    if (left) begin
      res = (o == `LID_ROW_LAST) ? 4'h0 : 4'(o + 4'h1);
    end else begin
      res = (o == 4'h0) ? `LID_ROW_LAST : 4'(o - 4'h1);
    end
    return res;
  endfunction

  // Control state of a full reset sequence; sync and blink run on
  function automatic lid_regs_t lid_init(input lid_regs_t c);
    lid_regs_t v;
    v          = c;
    v.st       = ST_CLEAR;
    v.cnt      = INIT_CYC;
    v.busy     = 1'b1;
    v.clr_addr = 7'h00;
    v.addr     = 7'h00;
    v.step_inc = 1'b1;
    v.shift_en = 1'b0;
    v.disp.display_visible = 1'b0;
    v.disp.cursor_visible  = 1'b0;
    v.disp.cursor_blink    = 1'b0;
    v.disp.display_offset  = 4'h0;
    v.disp.power_down      = 1'b0;
    v.disp.contrast_level  = 4'h0;
    return v;
  endfunction

  // Next-state logic
  always_comb begin
    n          = r;
    n.mem_we   = 1'b0;
    n.rd_valid = 1'b0;

    // Two-flop synchroniser on the reset pin, then a delayed copy
    n.pin_m = i_reset_pin_n;
    n.pin_s = r.pin_m;
    n.pin_d = r.pin_s;

    // measure how long the pin is low, saturating
    if (!r.pin_s) begin
      n.low_cnt = (r.low_cnt == 32'hffff_ffff) ? r.low_cnt
                                                : 32'(r.low_cnt + 32'd1);
    end else begin
      n.low_cnt = 32'h0;
    end

    // free-running blink phase, half period per toggle
    if (r.blink_cnt >= 32'(BLINK_HALF - 32'd1)) begin
      n.blink_cnt        = 32'h0;
      n.disp.blink_phase = ~r.disp.blink_phase;
    end else begin
      n.blink_cnt = 32'(r.blink_cnt + 32'd1);
    end

    // cursor row is five dots lit; blanked with the display
    n.disp.cursor_dots = (r.disp.cursor_visible && r.disp.display_visible)
                         ? 5'h1f : 5'h00;

    // key read is answered in any state, it takes no time
    if (i_xfer_valid && !i_xfer.register_select && i_xfer.rw) begin
      n.rd_valid = 1'b1;
      n.rd_data  = i_key_readout_select ? i_key_data : {r.busy, r.addr};
    end

    unique case (r.st)
      ST_IDLE: begin
        // route each write to its holding register
        if (i_xfer_valid && !i_xfer.rw) begin
          if (i_xfer.register_select) begin
            n.data_holding_register = i_xfer.data;
          end else begin
            n.instruction_holding_register = i_xfer.data;
          end
          n.hold_select = i_xfer.register_select;
          n.st      = ST_DECODE;
          n.busy    = 1'b1;
        end
      end

      ST_DECODE: begin
        n.st   = ST_IDLE;
        n.busy = 1'b0;
        if (r.hold_select) begin
          // store the data byte at the pointer
          n.mem_we   = 1'b1;
          n.mem_addr = r.addr;
          n.mem_data = r.data_holding_register;
          n.addr = lid_step(r.addr, r.step_inc);
          // character writes shift the display when enabled
          // glyph and icon writes never shift
          // character region lies below the glyph base
          if (r.shift_en && (r.addr < `LID_GLYPH_BASE)) begin
            n.disp.display_offset = lid_shift(r.disp.display_offset,
                                              r.step_inc);
          end
          n.st   = ST_WAIT;
          n.cnt  = EXEC_CYC;
          n.busy = 1'b1;
        end else if (r.instruction_holding_register[`LID_B_ADDR_SET]) begin
          n.addr = r.instruction_holding_register[6:0];
          n.st   = ST_WAIT;
          n.cnt  = EXEC_CYC;
          n.busy = 1'b1;
        end else if (r.instruction_holding_register[`LID_B_CONTRAST]) begin
          // contrast level from the low nibble
          n.disp.contrast_level = r.instruction_holding_register[3:0];
        end else if (r.instruction_holding_register[`LID_B_FUNCTION]) begin
          // power-down select; entering it also turns display off
          n.disp.power_down = ~r.instruction_holding_register[0];
          if (!r.instruction_holding_register[0]) begin
            n.disp.display_visible = 1'b0;
          end
        end else if (r.instruction_holding_register[`LID_B_SHIFT]) begin
          // RAM untouched; only a cursor move costs time
          // target one shifts display, direction one is right
          if (r.instruction_holding_register[3]) begin
            n.disp.display_offset = lid_shift(r.disp.display_offset,
              ~r.instruction_holding_register[2]);
          end else begin
            n.addr = lid_step(r.addr, r.instruction_holding_register[2]);
            n.st   = ST_WAIT;
            n.cnt  = EXEC_CYC;
            n.busy = 1'b1;
          end
        end else if (r.instruction_holding_register[`LID_B_DISPLAY]) begin
          // display off leaves memory as it is
          n.disp.display_visible = r.instruction_holding_register[2];
          n.disp.cursor_visible  = r.instruction_holding_register[1];
          n.disp.cursor_blink    = r.instruction_holding_register[0];
        end else if (r.instruction_holding_register[`LID_B_ENTRY]) begin
          n.step_inc = r.instruction_holding_register[1];
          n.shift_en = r.instruction_holding_register[0];
        end else if (r.instruction_holding_register[`LID_B_HOME]) begin
          // pointer home and shift cancelled, memory kept
          n.addr                = 7'h00;
          n.disp.display_offset = 4'h0;
          n.st                  = ST_WAIT;
          n.cnt                 = EXEC_CYC;
          n.busy                = 1'b1;
        end else if (r.instruction_holding_register[`LID_B_CLEAR]) begin
          // fill with spaces, pointer zero, increment forced
          // shift enable and other memories stay
          n.addr                = 7'h00;
          n.step_inc            = 1'b1;
          n.disp.display_offset = 4'h0;
          n.clr_addr            = 7'h00;
          n.st                  = ST_CLEAR;
          n.cnt                 = CLEAR_CYC;
          n.busy                = 1'b1;
        end
        // the all-zero test code falls through and does nothing
      end

      ST_CLEAR: begin
        // one character location per cycle, inside the wait time
        n.mem_we   = 1'b1;
        n.mem_addr = r.clr_addr;
        n.mem_data = `LID_SPACE_CODE;
        n.clr_addr = 7'(r.clr_addr + 7'h01);
        n.cnt      = (r.cnt > 32'd1) ? 32'(r.cnt - 32'd1) : 32'd1;
        if (r.clr_addr == `LID_CHAR_TOP) begin
          n.st = ST_WAIT;
        end
      end

      ST_WAIT: begin
        // transfers other than key reads are ignored while busy
        if (r.cnt <= 32'd1) begin
          n.st   = ST_IDLE;
          n.busy = 1'b0;
        end else begin
          n.cnt = 32'(r.cnt - 32'd1);
        end
      end
    endcase

    // long enough low pulse restarts the control state on the rising edge
    // busy then stands for the init time
    if (r.pin_s && !r.pin_d && (r.low_cnt >= RST_LOW_CYC)) begin
      n = lid_init(n);
    end
  end

  // State register; power-on behaves as a reset sequence
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r       <= lid_init('0);
      r.pin_m <= 1'b1;
      r.pin_s <= 1'b1;
      r.pin_d <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Shared memory with registered scan read
  lid_ram #(
    .AW (7),
    .DW (8)
  ) u_ram (
    .i_clk   (i_clk),
    .i_we    (r.mem_we),
    .i_waddr (r.mem_addr),
    .i_wdata (r.mem_data),
    .i_raddr (i_scan_addr),
    .o_rdata (o_scan_data)
  );

  // Outputs straight from the state register
  assign o_read_data           = r.rd_data;
  assign o_read_valid          = r.rd_valid;
  assign o_busy                = r.busy;
  assign o_ram_address_pointer = r.addr;
  assign o_step_inc            = r.step_inc;
  assign o_shift_enable        = r.shift_en;
  assign o_disp                = r.disp;

endmodule

`default_nettype wire

// ---- verif/lid_decoder_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port checker; decoded state lands two cycles after the transfer
module lid_decoder_chk
  import lid_pkg::*;
(
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst,
  // Transfers
  input wire logic       i_xfer_valid,
  input wire lid_xfer_t  i_xfer,
  input wire logic       i_key_readout_select,
  input wire logic [7:0] i_key_data,
  // Answers
  input wire logic [7:0] o_read_data,
  input wire logic       o_read_valid,
  input wire logic       o_busy,
  input wire logic [6:0] o_ram_address_pointer,
  input wire logic       o_step_inc,
  input wire logic       o_shift_enable,
  input wire lid_disp_t  o_disp
);
  logic       ins;
  logic       dw;
  logic [7:0] d;
  logic [6:0] p;
  // A write only counts when idle; busy writes are dropped
  assign ins = i_xfer_valid && !o_busy && !i_xfer.register_select
               && !i_xfer.rw;
  assign dw  = i_xfer_valid && !o_busy && i_xfer.register_select
               && !i_xfer.rw;
  assign d   = i_xfer.data;
  assign p   = o_ram_address_pointer;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_KEY: assert property (
    i_xfer_valid && !i_xfer.register_select && i_xfer.rw
    && i_key_readout_select
    |=> o_read_valid && o_read_data == $past(i_key_data))
    else $error("key read answer wrong");
  AST_TAKE: assert property (
    (ins && d != 8'h00) || dw |=> o_busy) else $error("write not taken");
  AST_ENTRY: assert property (
    ins && d[7:2] == 6'h01 |-> ##2 o_step_inc == $past(d[1], 2)
    && o_shift_enable == $past(d[0], 2)) else $error("entry mode wrong");
  AST_DISP: assert property (
    ins && d[7:3] == 5'h01 |-> ##2 {o_disp.display_visible,
    o_disp.cursor_visible, o_disp.cursor_blink} == $past(d[2:0], 2))
    else $error("display control wrong");
  AST_PWR: assert property (
    ins && d[7:5] == 3'h1 |-> ##2 o_disp.power_down != $past(d[0], 2))
    else $error("power-down wrong");
  AST_CON: assert property (
    ins && d[7:6] == 2'h1 |-> ##2
    o_disp.contrast_level == $past(d[3:0], 2)) else $error("contrast");
  AST_ADDR: assert property (
    ins && d[7] |-> ##2 p == $past(d[6:0], 2)) else $error("address set");
  AST_HOME: assert property (
    ins && d[7:1] == 7'h01 |-> ##2 p == 7'h00
    && o_disp.display_offset == 4'h0) else $error("return home");
  AST_CLEAR: assert property (
    ins && d == 8'h01 |-> ##2 p == 7'h00 && o_step_inc
    && o_shift_enable == $past(o_shift_enable, 2)) else $error("clear");
  AST_STEP: assert property (
    dw |-> ##2 p == ($past(o_step_inc, 2) ? $past(p, 2) + 7'h01
    : $past(p, 2) - 7'h01)) else $error("pointer step wrong");
  AST_DOTS: assert property (
    o_disp.cursor_visible && o_disp.display_visible
    |=> o_disp.cursor_dots == 5'h1f) else $error("cursor dots wrong");
endmodule
bind lid_decoder lid_decoder_chk u_chk (
  .i_clk, .i_rst, .i_xfer_valid, .i_xfer, .i_key_readout_select,
  .i_key_data, .o_read_data, .o_read_valid, .o_busy,
  .o_ram_address_pointer, .o_step_inc, .o_shift_enable, .o_disp
);
`default_nettype wire

// ---- verif/lid_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host on the serial side: sends transfers and works the reset pin
module lid_host
  import lid_pkg::*;
(
  // Clock and status
  input  wire logic      i_clk,
  input  wire logic      i_busy,
  // Towards the decoder, plus the hang flag for the bench
  output var  logic      o_valid,
  output var  lid_xfer_t o_xfer,
  output var  logic      o_reset_pin_n,
  output var  logic      o_hang
);
  // Idle levels
  initial begin
    o_valid = 1'b0;
    o_xfer = '0;
    o_reset_pin_n = 1'b1;
    o_hang = 1'b0;
  end
  // wait on busy; key reads go at once
  task automatic send(input logic       reg_sel,
                      input logic       rw,
                      input logic [7:0] d);
    int k;
    k = 0;
    while (!rw && i_busy && k < 2000) begin
      @(posedge i_clk);
      k++;
    end
    if (k == 2000) o_hang <= 1'b1;
    if (reg_sel || rw || d != 8'h00) begin
      o_valid <= 1'b1;
      o_xfer <= '{register_select: reg_sel, rw: rw, data: d};
      @(posedge i_clk);
      o_valid <= 1'b0;
      o_xfer <= ~o_xfer;
    end
    repeat (2) @(posedge i_clk);
  endtask
  task automatic pin(input int n);
    o_reset_pin_n <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_reset_pin_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- verif/test_lcd_instruction_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_lcd_instruction_decoder
  import lid_pkg::*;
;
  typedef struct packed {
    logic [7:0] cmd;
    logic [6:0] ptr;
    logic [1:0] sm;
    logic [2:0] dcb;
    logic       pwr;
    logic [3:0] con;
  } lid_row_t;
  localparam int INIT = 32'h64;
  logic       clk;
  logic       rst;
  logic       pin_n;
  logic       vld;
  lid_xfer_t  xf;
  logic       sel;
  logic [7:0] key;
  logic [6:0] sa;
  logic [7:0] sd;
  logic [7:0] rd;
  logic       busy;
  logic [6:0] ptr;
  logic       stp;
  logic       shf;
  lid_disp_t  disp;
  logic       hang;
  logic       rv;
  logic       b;
  int         bad_count;
  int         n_compared;
  int         n;
  // Instruction, then pointer, step/shift, D/C/B, power-down, contrast
  lid_row_t   rows [14] = '{
    '{8'h06, 7'h00, 2'h2, 3'h0, 1'h0, 4'h0},
    '{8'h0f, 7'h00, 2'h2, 3'h7, 1'h0, 4'h0},
    '{8'h20, 7'h00, 2'h2, 3'h3, 1'h1, 4'h0},
    '{8'h21, 7'h00, 2'h2, 3'h3, 1'h0, 4'h0},
    '{8'h0c, 7'h00, 2'h2, 3'h4, 1'h0, 4'h0},
    '{8'h7a, 7'h00, 2'h2, 3'h4, 1'h0, 4'ha},
    '{8'h85, 7'h05, 2'h2, 3'h4, 1'h0, 4'ha},
    '{8'h14, 7'h06, 2'h2, 3'h4, 1'h0, 4'ha},
    '{8'h10, 7'h05, 2'h2, 3'h4, 1'h0, 4'ha},
    '{8'h18, 7'h05, 2'h2, 3'h4, 1'h0, 4'ha},
    '{8'h05, 7'h05, 2'h1, 3'h4, 1'h0, 4'ha},
    '{8'h03, 7'h00, 2'h1, 3'h4, 1'h0, 4'ha},
    '{8'h8f, 7'h0f, 2'h1, 3'h4, 1'h0, 4'ha},
    '{8'h01, 7'h00, 2'h3, 3'h4, 1'h0, 4'ha}};
  // Counts shortened so the run stays brief
  lid_decoder #(
    .RST_LOW_CYC(32'h8),
    .INIT_CYC   (INIT),
    .CLEAR_CYC  (32'h50),
    .EXEC_CYC   (32'h5),
    .BLINK_HALF (32'h4)
  ) DUT (
    .i_clk                (clk),
    .i_rst                (rst),
    .i_reset_pin_n        (pin_n),
    .i_xfer_valid         (vld),
    .i_xfer               (xf),
    .i_key_readout_select (sel),
    .i_key_data           (key),
    .i_scan_addr          (sa),
    .o_scan_data          (sd),
    .o_read_data          (rd),
    .o_read_valid         (rv),
    .o_busy               (busy),
    .o_ram_address_pointer(ptr),
    .o_step_inc           (stp),
    .o_shift_enable       (shf),
    .o_disp               (disp)
  );
  lid_host u_host (
    .i_clk        (clk),
    .i_busy       (busy),
    .o_valid      (vld),
    .o_xfer       (xf),
    .o_reset_pin_n(pin_n),
    .o_hang       (hang)
  );
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Bounded wait for busy to drop; a hang ends the run
  task automatic idle(output int k);
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    if (k == 2000) begin
      chk(32'h1, 32'h0);
      results();
    end
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    sel = 1'b1;
    key = 8'ha5;
    sa = 7'h00;
    bad_count = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    chk({busy, ptr, stp, shf, disp.display_visible}, 32'h404);
    rst <= 1'b0;
    idle(n);
    chk(32'(n >= INIT - 10 && n <= INIT + 10), 32'h1);
    foreach (rows[i]) begin
      u_host.send(1'b0, 1'b0, rows[i].cmd);
      idle(n);
      chk({ptr, stp, shf, disp.display_visible, disp.cursor_visible,
           disp.cursor_blink, disp.power_down, disp.contrast_level},
          {rows[i].ptr, rows[i].sm, rows[i].dcb, rows[i].pwr,
           rows[i].con});
    end
    // Glyph write with shift on: pointer steps, display stays
    u_host.send(1'b0, 1'b0, 8'hc0);
    u_host.send(1'b1, 1'b0, 8'h55);
    idle(n);
    chk(ptr, 7'h41);
    chk(disp.display_offset, 4'h0);
    // Character write with shift on moves the display left
    u_host.send(1'b0, 1'b0, 8'h80);
    u_host.send(1'b1, 1'b0, 8'h41);
    idle(n);
    chk(disp.display_offset, 4'h1);
    u_host.send(1'b0, 1'b0, 8'h02);
    idle(n);
    chk({ptr, disp.display_offset}, 11'h0);
    // Clear overwrites characters, glyphs survive; key read while busy
    sel <= 1'b0;
    u_host.send(1'b0, 1'b0, 8'h01);
    u_host.send(1'b0, 1'b1, 8'h00);
    chk(rd, 8'h80);
    sel <= 1'b1;
    key <= 8'h5a;
    u_host.send(1'b0, 1'b1, 8'h00);
    chk(rd, 8'h5a);
    // Answer strobe stands one cycle only
    chk(rv, 1'b0);
    idle(n);
    sa <= 7'h40;
    repeat (2) @(posedge clk);
    chk(sd, 8'h55);
    sa <= 7'h00;
    repeat (2) @(posedge clk);
    chk(sd, 8'h20);
    // Decrement mode write steps down and shifts right
    u_host.send(1'b0, 1'b0, 8'h05);
    u_host.send(1'b0, 1'b0, 8'h83);
    u_host.send(1'b1, 1'b0, 8'h33);
    idle(n);
    chk({ptr, disp.display_offset}, {7'h02, 4'hb});
    // Short pin pulse is ignored, a long one restarts
    u_host.pin(4);
    repeat (8) @(posedge clk);
    chk(busy, 1'b0);
    u_host.pin(12);
    repeat (6) @(posedge clk);
    chk(busy, 1'b1);
    idle(n);
    chk(32'(n >= INIT - 20 && n <= INIT + 10), 32'h1);
    chk({ptr, disp.display_visible}, 8'h0);
    // Blink phase must flip once every shortened half period
    b = disp.blink_phase;
    repeat (4) @(posedge clk);
    chk(32'(disp.blink_phase != b), 32'h1);
    chk(hang, 1'b0);
    results();
  end
endmodule
`default_nettype wire
